// [verilog/mra_pkg.sv]
/*
 * Constants for the meter register access front end: command byte layout,
 * configuration register offset, field positions, reset value and timing.
 * Assumes a single 250 MHz core clock that also stands for the master clock.
 */
package mra_pkg;

   // ****************************************************************
   // Command byte layout
   // ****************************************************************
   localparam int unsigned MRA_CMD_WIDTH      = 8;
   localparam int unsigned MRA_ADDR_WIDTH     = 6;
   localparam int unsigned MRA_CMD_WRITE_BIT  = 7;
   localparam int unsigned MRA_CMD_SPARE_BIT  = 6;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [5:0]  MRA_OPERATING_CONFIGURATION_ADDR = 6'h09;
   localparam int unsigned MRA_CONFIG_WIDTH   = 16;
   localparam int unsigned MRA_DEFAULT_WIDTH  = 8;
   localparam logic [15:0] MRA_CONFIG_RESET   = 16'h000C;

   // ****************************************************************
   // Configuration field positions
   // ****************************************************************
   localparam int unsigned MRA_BIT_HIGHPASS_BYPASS      = 0;
   localparam int unsigned MRA_BIT_POWER_LOWPASS_BYPASS = 1;
   localparam int unsigned MRA_BIT_PULSE_OUTPUT_OFF     = 2;
   localparam int unsigned MRA_BIT_SAG_DETECT_OFF       = 3;
   localparam int unsigned MRA_BIT_CONVERTERS_DOWN      = 4;
   localparam int unsigned MRA_BIT_TEMPERATURE_START    = 5;
   localparam int unsigned MRA_BIT_SOFT_CHIP_RESET      = 6;
   localparam int unsigned MRA_BIT_LINE_CYCLE_ACC       = 7;
   localparam int unsigned MRA_BIT_CURRENT_SHORT        = 8;
   localparam int unsigned MRA_BIT_VOLTAGE_SHORT        = 9;
   localparam int unsigned MRA_BIT_INPUT_SWAP           = 10;
   localparam int unsigned MRA_BIT_RATE_LO              = 11;
   localparam int unsigned MRA_BIT_RATE_HI              = 12;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned MRA_CLOCK_PERIOD_NS     = 4;
   localparam int unsigned MRA_SOFT_RESET_HOLD_NS  = 18000;
   localparam int unsigned MRA_SOFT_RESET_HOLD_CYCLES =
      (MRA_SOFT_RESET_HOLD_NS + MRA_CLOCK_PERIOD_NS - 1) / MRA_CLOCK_PERIOD_NS;
   localparam int unsigned MRA_RATE_BASE_DIVIDE    = 128;
   localparam int unsigned MRA_RATE_COUNT_WIDTH    = 10;

endpackage : mra_pkg

// [verilog/mra_rate_if.sv]
/*
 * Carrier between the register front end and the waveform rate divider.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/1ns

interface mra_rate_if;
   logic [1:0] rate_select;
   logic       restart;
   logic       sample_tick;

   modport front   (output rate_select, output restart, input sample_tick);
   modport divider (input rate_select, input restart, output sample_tick);
endinterface : mra_rate_if

// [verilog/mra_rate_divider.sv]
/*
 * Waveform update rate divider: one-cycle tick every 128, 256, 512 or 1024
 * core clocks, chosen by the two rate select bits.
 * Assumes the core clock stands for the master clock input.
 */
`timescale 1ns/1ns

module mra_rate_divider
   import mra_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   mra_rate_if.divider rate
);

   logic [MRA_RATE_COUNT_WIDTH-1:0] count_reg;
   logic [MRA_RATE_COUNT_WIDTH-1:0] count_next;
   logic                            tick_reg;
   logic                            tick_next;
   logic [MRA_RATE_COUNT_WIDTH-1:0] last_count;

   // ****************************************************************
   // Divider
   // ****************************************************************

   // Terminal count is the divide ratio minus one
   always_comb
   begin
      last_count = MRA_RATE_COUNT_WIDTH'((MRA_RATE_BASE_DIVIDE << rate.rate_select) - 1);
      tick_next  = 1'b0;
      count_next = count_reg + 1'b1;
      if (rate.restart)
      begin
         count_next = '0;
      end
      else if (count_reg >= last_count)
      begin
         // A lowered ratio never strands the counter above its new limit
         count_next = '0;
         tick_next  = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         count_reg <= '0;
         tick_reg  <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         tick_reg  <= tick_next;
      end
   end

   assign rate.sample_tick = tick_reg;

endmodule : mra_rate_divider

// [verilog/mra_register_front.sv]
/*
 * Host-facing register access front end with the operating configuration
 * register. A serial frame carries a command byte then one data transfer.
 * Assumes all pins are synchronous to the core clock, the host idles the
 * serial clock high, and the core clock stands for the master clock input.
 */
`timescale 1ns/1ns

// Summary of operation
// - Command byte is eight bits, write-only, choosing direction and target register.
// - Command bits 0 to 5 address the register of the following transfer.
// - Command bit 7 high makes the following transfer a register write.
// - Command bit 7 low makes the following transfer a register read.
// - Configuration register sits at address 0x09 and is host writable.
// - Configuration bit 0 bypasses the current channel high-pass filter.
// - Configuration bit 1 disables the low-pass filter after the power multiplier.
// - Configuration bit 4 powers down both converters; keep clear normally.
// - Bit 5 starts temperature conversion and clears itself when conversion finishes.
// - Configuration bit 7 selects line-cycle energy accumulation mode.
// - Configuration bit 8 shorts the current converter inputs together.
// - Configuration bit 9 shorts the voltage converter inputs together.
// - Configuration bit 10 swaps which input pair feeds each converter.
// - Bits 12 and 11 pick waveform rate: clock over 128, 256, 512, 1024.
module mra_register_front
   import mra_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = MRA_SOFT_RESET_HOLD_CYCLES
)
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic serial_clock,
   input  wire logic serial_select_n,
   input  wire logic serial_data_in,
   input  wire logic temperature_done,
   output logic      serial_data_out,
   output logic      serial_data_out_en,
   output logic      highpass_bypass,
   output logic      power_lowpass_bypass,
   output logic      pulse_output_off,
   output logic      sag_detect_off,
   output logic      converters_power_down,
   output logic      temperature_conversion_start,
   output logic      line_cycle_accumulation,
   output logic      current_input_short,
   output logic      voltage_input_short,
   output logic      input_swap,
   output logic      soft_chip_reset,
   output logic      soft_reset_holdoff,
   output logic      waveform_sample_tick
);

   localparam int unsigned HOLD_WIDTH = $clog2(HOLD_CYCLES + 1);

   typedef enum {
      ST_COMMAND,
      ST_WRITE,
      ST_READ,
      ST_HOLD
   } mra_state_type;

   // Data length of a transfer for a given target register
   function automatic logic [4:0] transfer_length(input logic [5:0] addr);
      if (addr == MRA_OPERATING_CONFIGURATION_ADDR)
      begin
         transfer_length = 5'(MRA_CONFIG_WIDTH);
      end
      else
      begin
         transfer_length = 5'(MRA_DEFAULT_WIDTH);
      end
   endfunction : transfer_length

   mra_state_type             state_reg;
   mra_state_type             state_next;
   logic                      sclk_prev_reg;
   logic [4:0]                bits_reg;
   logic [4:0]                bits_next;
   logic [15:0]               shift_reg;
   logic [15:0]               shift_next;
   logic [5:0]                addr_reg;
   logic [5:0]                addr_next;
   logic                      dout_reg;
   logic                      dout_next;
   logic                      dout_en_reg;
   logic                      dout_en_next;
   logic [15:0]               config_reg;
   logic [15:0]               config_next;
   logic                      soft_pulse_reg;
   logic                      soft_pulse_next;
   logic [HOLD_WIDTH-1:0]     hold_reg;
   logic [HOLD_WIDTH-1:0]     hold_next;
   logic                      holdoff_reg;
   logic                      holdoff_next;
   logic                      sclk_rise;
   logic                      sclk_fall;
   logic [15:0]               shifted_in;

   mra_rate_if rate ();

   // ****************************************************************
   // Serial framing and command decode
   // ****************************************************************

   // Host samples on the falling edge, so the device shifts in on it too
   assign sclk_rise  = serial_clock & ~sclk_prev_reg;
   assign sclk_fall  = ~serial_clock & sclk_prev_reg;
   assign shifted_in = {shift_reg[14:0], serial_data_in};

   // One state machine covers the command byte, data phase and reset holdoff
   always_comb
   begin
      state_next      = state_reg;
      bits_next       = bits_reg;
      shift_next      = shift_reg;
      addr_next       = addr_reg;
      dout_next       = dout_reg;
      dout_en_next    = dout_en_reg;
      config_next     = config_reg;
      soft_pulse_next = 1'b0;
      hold_next       = hold_reg;

      // Conversion done clears the start bit; a host write below still wins
      if (temperature_done)
      begin
         config_next[MRA_BIT_TEMPERATURE_START] = 1'b0;
      end

      unique case (state_reg)
         ST_COMMAND:
         begin
            dout_en_next = 1'b0;
            if (serial_select_n)
            begin
               bits_next = '0;
            end
            else if (sclk_fall)
            begin
               // Every frame opens with the eight command bits
               shift_next = shifted_in;
               bits_next  = bits_reg + 1'b1;
               if (bits_reg == 5'(MRA_CMD_WIDTH - 1))
               begin
                  // Bit 6 carries no meaning and is dropped
                  addr_next = shifted_in[MRA_ADDR_WIDTH-1:0];
                  bits_next = '0;
                  if (shifted_in[MRA_CMD_WRITE_BIT])
                  begin
                     state_next = ST_WRITE;
                  end
                  else
                  begin
                     state_next = ST_READ;
                     // Read data left aligned so the MSB goes out first
                     if (shifted_in[MRA_ADDR_WIDTH-1:0] == MRA_OPERATING_CONFIGURATION_ADDR)
                     begin
                        shift_next = config_reg;
                     end
                     else
                     begin
                        shift_next = '0;
                     end
                  end
               end
            end
         end

         ST_WRITE:
         begin
            if (serial_select_n)
            begin
               // Frame dropped mid transfer: nothing is committed
               state_next = ST_COMMAND;
               bits_next  = '0;
            end
            else if (sclk_fall)
            begin
               shift_next = shifted_in;
               bits_next  = bits_reg + 1'b1;
               if (bits_reg == transfer_length(addr_reg) - 5'd1)
               begin
                  state_next = ST_COMMAND;
                  bits_next  = '0;
                  if (addr_reg == MRA_OPERATING_CONFIGURATION_ADDR)
                  begin
                     config_next = shifted_in;
                     if (shifted_in[MRA_BIT_SOFT_CHIP_RESET])
                     begin
                        // Soft reset restores defaults and bars the host a while
                        config_next     = MRA_CONFIG_RESET;
                        soft_pulse_next = 1'b1;
                        hold_next       = HOLD_WIDTH'(HOLD_CYCLES);
                        state_next      = ST_HOLD;
                     end
                  end
               end
            end
         end

         ST_READ:
         begin
            if (serial_select_n)
            begin
               state_next   = ST_COMMAND;
               bits_next    = '0;
               dout_en_next = 1'b0;
            end
            else if (sclk_rise)
            begin
               // Next bit goes out on the rise, ready for the host's fall
               dout_next    = shift_reg[15];
               dout_en_next = 1'b1;
               shift_next   = {shift_reg[14:0], 1'b0};
            end
            else if (sclk_fall)
            begin
               bits_next = bits_reg + 1'b1;
               if (bits_reg == transfer_length(addr_reg) - 5'd1)
               begin
                  state_next = ST_COMMAND;
                  bits_next  = '0;
               end
            end
         end

         ST_HOLD:
         begin
            // Frames seen during the holdoff are ignored outright
            dout_en_next = 1'b0;
            bits_next    = '0;
            if (hold_reg == '0)
            begin
               state_next = ST_COMMAND;
            end
            else
            begin
               hold_next = hold_reg - 1'b1;
            end
         end
      endcase

      // The self-clearing reset bit never reads back as set
      config_next[MRA_BIT_SOFT_CHIP_RESET] = 1'b0;

      // Registered copy so the holdoff pin comes straight off a flop
      holdoff_next = (state_next == ST_HOLD);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg      <= ST_COMMAND;
         sclk_prev_reg  <= 1'b1;
         bits_reg       <= '0;
         shift_reg      <= '0;
         addr_reg       <= '0;
         dout_reg       <= 1'b0;
         dout_en_reg    <= 1'b0;
         config_reg     <= MRA_CONFIG_RESET;
         soft_pulse_reg <= 1'b0;
         hold_reg       <= '0;
         holdoff_reg    <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         sclk_prev_reg  <= serial_clock;
         bits_reg       <= bits_next;
         shift_reg      <= shift_next;
         addr_reg       <= addr_next;
         dout_reg       <= dout_next;
         dout_en_reg    <= dout_en_next;
         config_reg     <= config_next;
         soft_pulse_reg <= soft_pulse_next;
         hold_reg       <= hold_next;
         holdoff_reg    <= holdoff_next;
      end
   end

   // ****************************************************************
   // Configuration outputs
   // ****************************************************************

   // Each control but soft_chip_reset comes straight off its configuration flop
   assign highpass_bypass              = config_reg[MRA_BIT_HIGHPASS_BYPASS];
   assign power_lowpass_bypass         = config_reg[MRA_BIT_POWER_LOWPASS_BYPASS];
   assign pulse_output_off             = config_reg[MRA_BIT_PULSE_OUTPUT_OFF];
   assign sag_detect_off               = config_reg[MRA_BIT_SAG_DETECT_OFF];
   assign converters_power_down        = config_reg[MRA_BIT_CONVERTERS_DOWN];
   assign temperature_conversion_start = config_reg[MRA_BIT_TEMPERATURE_START];
   assign line_cycle_accumulation      = config_reg[MRA_BIT_LINE_CYCLE_ACC];
   assign current_input_short          = config_reg[MRA_BIT_CURRENT_SHORT];
   assign voltage_input_short          = config_reg[MRA_BIT_VOLTAGE_SHORT];
   assign input_swap                   = config_reg[MRA_BIT_INPUT_SWAP];
   assign soft_chip_reset              = soft_pulse_reg;
   assign serial_data_out              = dout_reg;
   assign serial_data_out_en           = dout_en_reg;
   assign soft_reset_holdoff           = holdoff_reg;

   // ****************************************************************
   // Waveform update rate
   // ****************************************************************

   // Divider restarts with a soft reset so the new rate starts clean
   assign rate.rate_select = config_reg[MRA_BIT_RATE_HI:MRA_BIT_RATE_LO];
   assign rate.restart     = soft_pulse_reg;
   assign waveform_sample_tick = rate.sample_tick;

   mra_rate_divider u_rate_divider (
      .clock (clock),
      .rst   (rst),
      .rate  (rate.divider)
   );

endmodule : mra_register_front

// [tb/mra_register_front_sva.sv]
/* Port assertions for the register front end.
   Assumes one core clock, synchronous active-high rst. */
`timescale 1ns/1ns
module mra_register_front_sva
#(
   parameter int unsigned HOLD_CYCLES = 8
)
(
   input logic clock,
   input logic rst,
   input logic serial_clock,
   input logic serial_select_n,
   input logic serial_data_in,
   input logic temperature_done,
   input logic serial_data_out,
   input logic serial_data_out_en,
   input logic highpass_bypass,
   input logic power_lowpass_bypass,
   input logic pulse_output_off,
   input logic sag_detect_off,
   input logic converters_power_down,
   input logic temperature_conversion_start,
   input logic line_cycle_accumulation,
   input logic current_input_short,
   input logic voltage_input_short,
   input logic input_swap,
   input logic soft_chip_reset,
   input logic soft_reset_holdoff,
   input logic waveform_sample_tick
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [10:0] gap_reg, gap_next;
   logic        clean_reg, clean_next;
   logic [15:0] hold_reg, hold_next;

   // Tick spacing is only judged when no frame may have moved the rate
   always_comb
   begin
      gap_next   = waveform_sample_tick ? 11'h001 : gap_reg + {10'h000, ~&gap_reg};
      clean_next = waveform_sample_tick | (clean_reg & serial_select_n & ~soft_chip_reset);
      hold_next  = soft_reset_holdoff ? hold_reg + 16'h0001 : 16'h0000;
   end

   // Helper registers
   always_ff @(posedge clock)
   begin
      gap_reg   <= rst ? 11'h000 : gap_next;
      clean_reg <= rst ? 1'b0 : clean_next;
      hold_reg  <= rst ? 16'h0000 : hold_next;
   end

   rst_values_a: assert property (disable iff (1'b0)
      rst |=> pulse_output_off && sag_detect_off && !highpass_bypass && !input_swap)
      else $error("outputs not at reset values");
   soft_defaults_a: assert property (
      soft_chip_reset |-> ##[0:1] (pulse_output_off && sag_detect_off && !highpass_bypass))
      else $error("soft reset left configuration set");
   cfg_quiet_a: assert property (
      serial_select_n && $past(serial_select_n) && $past(serial_select_n, 2)
      && !soft_chip_reset && !$past(soft_chip_reset)
      |-> $stable({highpass_bypass, power_lowpass_bypass, line_cycle_accumulation,
                   converters_power_down, input_swap, current_input_short}))
      else $error("configuration changed with no frame");
   temp_clear_a: assert property (
      temperature_done && serial_select_n && $past(serial_select_n)
      |=> !temperature_conversion_start)
      else $error("temperature start not cleared");
   temp_hold_a: assert property (
      $fell(temperature_conversion_start) |-> $past(temperature_done)
      || !$past(serial_select_n) || soft_chip_reset || $past(soft_chip_reset))
      else $error("temperature start dropped by itself");
   en_idle_a: assert property (
      serial_select_n && $past(serial_select_n) |-> !serial_data_out_en)
      else $error("data out enabled outside a frame");
   tick_gap_a: assert property (
      waveform_sample_tick && clean_reg |-> gap_reg inside {128, 256, 512, 1024})
      else $error("waveform tick spacing wrong");
   hold_len_a: assert property (
      $fell(soft_reset_holdoff) |-> hold_reg == 16'(HOLD_CYCLES + 1))
      else $error("holdoff length wrong");
   pulse_one_a: assert property (
      soft_chip_reset |=> (!soft_chip_reset)[*8])
      else $error("soft reset pulse repeated");
endmodule : mra_register_front_sva

bind mra_register_front mra_register_front_sva #(.HOLD_CYCLES(HOLD_CYCLES))
   mra_register_front_sva_inst (.clock, .rst, .serial_clock, .serial_select_n,
   .serial_data_in, .temperature_done, .serial_data_out, .serial_data_out_en,
   .highpass_bypass, .power_lowpass_bypass, .pulse_output_off, .sag_detect_off,
   .converters_power_down, .temperature_conversion_start, .line_cycle_accumulation,
   .current_input_short, .voltage_input_short, .input_swap, .soft_chip_reset,
   .soft_reset_holdoff, .waveform_sample_tick);

// [tb/mra_host_model.sv]
/* Host side of the serial register link, one frame per call.
   Assumes the core clock paces it: serial clock 2 clocks low, 4 high. */
`timescale 1ns/1ns
module mra_host_model
(
   input  wire logic clock,
   input  wire logic serial_data_out,
   input  wire logic serial_data_out_en,
   output logic      serial_clock,
   output logic      serial_select_n,
   output logic      serial_data_in
);
   // Idle: serial clock high, frame deselected
   initial
   begin
      serial_clock    = 1'b1;
      serial_select_n = 1'b1;
      serial_data_in  = 1'b0;
   end

   // Command then n data bits MSB first; n shorter than the register aborts
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                       output logic [15:0] rd);
      logic [23:0] bits;
      bits = {cmd[7], 1'b0, cmd[5:0], wd << (16 - n)};
      rd   = 16'h0000;
      @(posedge clock);
      serial_select_n <= 1'b0;
      repeat (2) @(posedge clock);
      for (int i = 0; i < 8 + n; i++)
      begin
         serial_clock   <= 1'b0;
         serial_data_in <= bits[23 - i];
         repeat (2) @(posedge clock);
         serial_clock <= 1'b1;
         // Device answers a rise late, so sample at the end of the high phase
         repeat (4) @(posedge clock);
         if (i >= 7 && i < 7 + n)
            // An undriven line reads inverted, so a missing enable corrupts the data
            rd = {rd[14:0], serial_data_out_en ? serial_data_out : ~serial_data_out};
      end
      serial_select_n <= 1'b1;
      serial_data_in  <= ~serial_data_in; // No stale bit left on a released line
      repeat (4) @(posedge clock);
   endtask : xfer
endmodule : mra_host_model

// [tb/test_meter_register_access_and_mode_control.sv]
/* Self-checking bench: register frames, pin levels, tick spacing, soft reset.
   Assumes the host model paces the link; holdoff is shortened. */
`timescale 1ns/1ns
module test_meter_register_access_and_mode_control;
   import mra_pkg::*;
   localparam int unsigned HOLD = 400;
   logic clock, rst, temperature_done, serial_clock, serial_select_n, serial_data_in;
   logic serial_data_out, serial_data_out_en, highpass_bypass, power_lowpass_bypass;
   logic pulse_output_off, sag_detect_off, converters_power_down, input_swap;
   logic temperature_conversion_start, line_cycle_accumulation, current_input_short;
   logic voltage_input_short, soft_chip_reset, soft_reset_holdoff, waveform_sample_tick;
   logic [15:0] v;
   int          g, num_errors, tests_run, resets_seen;
   int          bl[9] = '{0, 1, 2, 3, 4, 7, 8, 9, 10};
   logic [5:0]  odd[5] = '{6'h0A, 6'h19, 6'h29, 6'h08, 6'h0B};
   wire logic [15:0] pins = {6'h00, input_swap, voltage_input_short, current_input_short,
      line_cycle_accumulation, temperature_conversion_start, converters_power_down,
      sag_detect_off, pulse_output_off, power_lowpass_bypass, highpass_bypass};

   mra_register_front #(.HOLD_CYCLES(HOLD)) mra_register_front_inst (.clock, .rst,
      .serial_clock, .serial_select_n, .serial_data_in, .temperature_done,
      .serial_data_out, .serial_data_out_en, .highpass_bypass, .power_lowpass_bypass,
      .pulse_output_off, .sag_detect_off, .converters_power_down,
      .temperature_conversion_start, .line_cycle_accumulation, .current_input_short,
      .voltage_input_short, .input_swap, .soft_chip_reset, .soft_reset_holdoff,
      .waveform_sample_tick);
   mra_host_model mra_host_model_inst (.clock, .serial_data_out, .serial_data_out_en, .serial_clock,
      .serial_select_n, .serial_data_in);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] outs(input logic [15:0] c);
      return {6'h00, c[10:7], c[5:0]};
   endfunction : outs

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Only the configuration register carries 16 data bits
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] r;
      mra_host_model_inst.xfer({2'b10, a}, d, (a == 6'h09) ? 16 : 8, r);
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      mra_host_model_inst.xfer({2'b00, a}, 16'h0000, (a == 6'h09) ? 16 : 8, d);
   endtask : rd

   // Waits for a tick, then counts clocks to the next one
   task automatic gap(output int n);
      n = 0;
      while (waveform_sample_tick !== 1'b1 && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      n = 1;
      while (waveform_sample_tick !== 1'b1 && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
   endtask : gap

   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // ****************************************************************
   // Clock, pulse counter and watchdog
   // ****************************************************************
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // A stretched pulse counts twice, so its width is checked too
   always @(posedge clock)
      if (soft_chip_reset === 1'b1)
         resets_seen++;

   // Run is about 10k clocks; ten times that marks a hang
   initial
   begin
      repeat (100000) @(posedge clock);
      num_errors++;
      conclude();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      rst              = 1'b1;
      temperature_done = 1'b0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rd(6'h09, v);
      check(v, 16'h000C);
      check(pins, outs(16'h000C));
      foreach (bl[k])
      begin
         wr(6'h09, 16'h0001 << bl[k]);
         rd(6'h09, v);
         check(v, 16'h0001 << bl[k]);
         check(pins, outs(16'h0001 << bl[k]));
      end
      wr(6'h09, 16'h0020);
      check(pins, outs(16'h0020));
      temperature_done <= 1'b1;
      @(posedge clock);
      temperature_done <= 1'b0;
      repeat (2) @(posedge clock);
      check(pins, outs(16'h0000));
      foreach (odd[k])
         wr(odd[k], 16'h00FF);
      rd(6'h09, v);
      check(v, 16'h0000);
      rd(6'h0A, v);
      check(v, 16'h0000);
      mra_host_model_inst.xfer(8'h89, 16'h00FF, 8, v);
      rd(6'h09, v);
      check(v, 16'h0000);
      for (int r = 0; r < 4; r++)
      begin
         wr(6'h09, 16'(r) << 11);
         rd(6'h09, v);
         check(v, 16'(r) << 11);
         gap(g);
         check(16'(g), 16'(128 << r));
      end
      wr(6'h09, 16'h0043);
      check(16'(resets_seen), 16'h0001);
      check(16'(soft_reset_holdoff), 16'h0001);
      check(pins, outs(16'h000C));
      wr(6'h09, 16'h0001);
      repeat (HOLD) @(posedge clock);
      check(16'(soft_reset_holdoff), 16'h0000);
      rd(6'h09, v);
      check(v, 16'h000C);
      conclude();
   end
endmodule : test_meter_register_access_and_mode_control
